// ### src/lin_status_flags.sv
// Purpose: status, data, checksum and interrupt flag logic of a serial bus controller
// Assumes: bus engine supplies one-cycle event pulses on this clock
// Notes: status read clears only the read-clearable bits it returned
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lin_status_params.svh"

// What this block does
// - set wake-up flag on bus wake when low-power bit is zero; status read clears.
// - flag first break after enable that outlasts maximum count; status read clears.
// - PID parity flag follows the current data byte, payload or identifier alike.
// - checksum mismatch flag while receive ready; clears on match, or on status read once receive ready has dropped.
// - frame error flag on missing stop bit; status read clears.
// - flag 57 or more falling edges in one frame; status read clears.
// - collision flag unless combined mode and transmit complete already set.
// - break flag after 11 bit times low; status read clears.
// - transmit complete set after all data sent, held until break or data write, cleared receiving.
// - transmit ready low until byte moves to shifter; rewrite replaces pending.
// - receive ready set on new byte; data register read clears it.
// - five sources individually maskable onto the interrupt output.
module lin_status_flags #(
    parameter int BIT_CLOCKS = 6250
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire lin_status_pkg::reg_req_s i_req,
    output logic [15:0] o_rdata,
    input wire lin_status_pkg::bus_events_s i_evt,
    input wire logic i_rxd,
    input wire logic i_frame_start,
    input wire logic i_low_power,
    output logic o_tx_pending,
    output logic [7:0] o_tx_byte,
    output logic o_enable,
    output logic o_irq
);
    import lin_status_pkg::*;

    logic [15:0] status_q;
    logic [15:0] status_d;
    logic [15:0] control_q;
    logic [15:0] mask_q;
    logic [7:0] data_q;
    logic [7:0] csum_q;
    logic [15:0] rdata_q;
    logic rxd_meta_q;
    logic rxd_sync_q;
    logic first_break_q;
    logic low_power_meta_q;
    logic low_power_q;

    wire wr_status = i_req.wr && i_req.addr == `ADDR_STATUS;
    wire wr_data = i_req.wr && i_req.addr == `ADDR_DATA;
    wire wr_csum = i_req.wr && i_req.addr == `ADDR_CHECKSUM;
    wire wr_ctrl = i_req.wr && i_req.addr == `ADDR_CONTROL;
    wire wr_mask = i_req.wr && i_req.addr == `ADDR_IRQ_MASK;
    wire rd_status = i_req.rd && i_req.addr == `ADDR_STATUS;
    wire rd_data = i_req.rd && i_req.addr == `ADDR_DATA;

    wire neg_edge_max;
    wire break_seen;
    wire pid_bad;

    lin_bus_monitor #(
        .BIT_CLOCKS(BIT_CLOCKS)
    ) u_monitor (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_rxd(rxd_sync_q),
        .i_frame_start(i_frame_start),
        .o_neg_edge_max(neg_edge_max),
        .o_break_seen(break_seen)
    );

    // judged on the incoming byte so bit 8 matches the data register it sits beside
    lin_pid_check u_pid (
        .i_byte(next_data),
        .o_parity_bad(pid_bad)
    );

    // bits a status read clears: everything except ready, done, ready-tx, pid
    localparam logic [15:0] READ_CLEAR = 16'h06f8;
    wire [15:0] rd_clear = rd_status ? (status_q & READ_CLEAR) : 16'h0000;

    wire enabling = wr_ctrl && i_req.wdata[`CTRL_ENABLE] && !control_q[`CTRL_ENABLE];
    wire collision_ok = control_q[`CTRL_COLL_SEP] || !status_q[`BIT_TX_DONE];
    wire [7:0] next_data = i_evt.rx_byte ? i_evt.rx_data : (wr_data ? i_req.wdata[7:0] : data_q);
    wire rx_ready_next = i_evt.rx_byte || (status_q[`BIT_RX_READY] && !rd_data);

    always_comb begin
        status_d = status_q & ~rd_clear;
        // set terms follow the clear so a same-cycle event wins
        if (i_evt.wakeup && !low_power_q) status_d[`BIT_WAKEUP] = 1'b1;
        if (i_evt.break_max && first_break_q) status_d[`BIT_BREAK_MAX] = 1'b1;
        if (i_evt.frame_err) status_d[`BIT_FRAME_ERR] = 1'b1;
        if (neg_edge_max) status_d[`BIT_NEG_EDGE] = 1'b1;
        if (i_evt.collision && collision_ok) status_d[`BIT_COLLISION] = 1'b1;
        if (break_seen) status_d[`BIT_BREAK_RX] = 1'b1;
        if (rx_ready_next) begin
            if (next_data != csum_q) status_d[`BIT_CSUM_ERR] = 1'b1;
            else status_d[`BIT_CSUM_ERR] = 1'b0;
        end
        // transmit complete: held until a break or a data write, dropped in receive mode
        if (i_evt.rx_mode || break_seen) status_d[`BIT_TX_DONE] = 1'b0;
        else if (wr_data) status_d[`BIT_TX_DONE] = 1'b0;
        else if (i_evt.tx_done) status_d[`BIT_TX_DONE] = 1'b1;
        // a rewrite before the shifter takes the byte simply replaces it
        if (wr_data) status_d[`BIT_TX_READY] = 1'b0;
        else if (i_evt.tx_loaded) status_d[`BIT_TX_READY] = 1'b1;
        status_d[`BIT_RX_READY] = rx_ready_next;
        status_d[`BIT_PID_ERR] = pid_bad;
        status_d = status_d & `STATUS_USED;
    end

    wire [15:0] rd_mux = rd_status ? status_q :
                         rd_data ? {8'h00, data_q} :
                         (i_req.rd && i_req.addr == `ADDR_CHECKSUM) ? {8'h00, csum_q} :
                         (i_req.rd && i_req.addr == `ADDR_CONTROL) ? control_q :
                         (i_req.rd && i_req.addr == `ADDR_IRQ_MASK) ? mask_q : 16'h0000;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            status_q <= `STATUS_RESET;
            control_q <= `CONTROL_RESET;
            mask_q <= `MASK_RESET;
            data_q <= 8'h00;
            csum_q <= 8'h00;
            rdata_q <= 16'h0000;
        end else begin
            status_q <= status_d;
            data_q <= next_data;
            rdata_q <= rd_mux;
            if (wr_csum) csum_q <= i_req.wdata[7:0];
            if (wr_ctrl) control_q <= i_req.wdata;
            if (wr_mask) mask_q <= i_req.wdata & `IRQ_SOURCES;
        end
    end

    // pin-side levels pass two flops before use
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rxd_meta_q <= 1'b1;
            rxd_sync_q <= 1'b1;
            low_power_meta_q <= 1'b0;
            low_power_q <= 1'b0;
        end else begin
            rxd_meta_q <= i_rxd;
            rxd_sync_q <= rxd_meta_q;
            low_power_meta_q <= i_low_power;
            low_power_q <= low_power_meta_q;
        end
    end

    // only the first break after enabling is judged for overrun
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) first_break_q <= 1'b0;
        else if (enabling) first_break_q <= 1'b1;
        else if (break_seen || i_evt.break_max) first_break_q <= 1'b0;
    end

    // status writes are ignored; flags clear by reads, data and checksum writes and bus events only
    wire unused_wr = wr_status;

    assign o_rdata = rdata_q;
    assign o_tx_pending = !status_q[`BIT_TX_READY];
    assign o_tx_byte = data_q;
    assign o_enable = control_q[`CTRL_ENABLE];
    assign o_irq = |(status_q & mask_q & `IRQ_SOURCES);
endmodule
`default_nettype wire

// ### inc/lin_status_params.svh
// Purpose: offsets, field positions and timing counts of the bus status block
// Assumes: 16-bit registers behind a plain strobe port
// Notes: definitions only
`ifndef LIN_STATUS_PARAMS_SVH
`define LIN_STATUS_PARAMS_SVH

`define ADDR_STATUS 4'h0
`define ADDR_DATA 4'h1
`define ADDR_CHECKSUM 4'h2
`define ADDR_CONTROL 4'h3
`define ADDR_IRQ_MASK 4'h4

`define BIT_RX_READY 0
`define BIT_TX_READY 1
`define BIT_TX_DONE 2
`define BIT_BREAK_RX 3
`define BIT_COLLISION 4
`define BIT_NEG_EDGE 5
`define BIT_FRAME_ERR 6
`define BIT_CSUM_ERR 7
`define BIT_PID_ERR 8
`define BIT_BREAK_MAX 9
`define BIT_WAKEUP 10

`define CTRL_COLL_SEP 6
`define CTRL_ENABLE 11
`define STATUS_RESET 16'h0002
`define CONTROL_RESET 16'h0000
`define MASK_RESET 16'h0000
`define STATUS_USED 16'h07ff
// maskable sources: tx ready, tx done, break, collision, negative edge
`define IRQ_SOURCES 16'h003e
`define NEG_EDGE_LIMIT 57
`define BREAK_BITS 11

`endif

// ### inc/lin_status_pkg.sv
// Purpose: types shared by the bus status block
// Assumes: nothing beyond the params header
// Notes: event bundle carries one-cycle pulses from the bus engine
package lin_status_pkg;

    typedef struct packed {
        logic wakeup;
        logic break_max;
        logic frame_err;
        logic collision;
        logic tx_loaded;
        logic tx_done;
        logic rx_byte;
        logic rx_mode;
        logic [7:0] rx_data;
    } bus_events_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

// ### src/lin_pid_check.sv
// Purpose: protected identifier parity check of one byte
// Assumes: bits 0..5 identifier, bits 6 and 7 parity
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module lin_pid_check (
    input wire logic [7:0] i_byte,
    output logic o_parity_bad
);
    wire p0 = i_byte[0] ^ i_byte[1] ^ i_byte[2] ^ i_byte[4];
    wire p1 = ~(i_byte[1] ^ i_byte[3] ^ i_byte[4] ^ i_byte[5]);
    assign o_parity_bad = (p0 != i_byte[6]) || (p1 != i_byte[7]);
endmodule
`default_nettype wire

// ### src/lin_bus_monitor.sv
// Purpose: counts falling edges per frame and times low bus for a break
// Assumes: rxd already synchronised; bit time given in clocks
// Notes: one-cycle pulses out
`timescale 1ns/1ps
`default_nettype none
`include "lin_status_params.svh"
module lin_bus_monitor #(
    parameter int BIT_CLOCKS = 6250
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_rxd,
    input wire logic i_frame_start,
    output logic o_neg_edge_max,
    output logic o_break_seen
);
    localparam int BREAK_CLOCKS = BIT_CLOCKS * `BREAK_BITS;
    localparam int LW = $clog2(BREAK_CLOCKS + 1);
    initial begin
        if (BIT_CLOCKS < 1) $error("BIT_CLOCKS must be positive");
    end
    logic rxd_q;
    logic [5:0] edges_q;
    logic [LW-1:0] low_q;
    wire fall = rxd_q & ~i_rxd;
    wire edge_hit = fall && (edges_q == 6'(`NEG_EDGE_LIMIT - 1));
    wire low_hit = !i_rxd && (low_q == LW'(BREAK_CLOCKS - 1));
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rxd_q <= 1'b1;
            edges_q <= 6'h00;
            low_q <= '0;
        end else begin
            rxd_q <= i_rxd;
            if (i_frame_start) edges_q <= 6'h00;
            else if (fall && edges_q != 6'h3f) edges_q <= edges_q + 6'h01;
            if (i_rxd) low_q <= '0;
            else if (low_q != LW'(BREAK_CLOCKS)) low_q <= low_q + LW'(1);
        end
    end
    assign o_neg_edge_max = edge_hit;
    assign o_break_seen = low_hit;
endmodule
`default_nettype wire

// ### dv/lin_status_properties.sv
// Purpose: port checks of the bus status block
// Assumes: one clock, sync active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "lin_status_params.svh"
module lin_status_properties (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire lin_status_pkg::reg_req_s i_req,
    input wire lin_status_pkg::bus_events_s i_evt,
    input wire logic [15:0] o_rdata,
    input wire logic o_tx_pending,
    input wire logic [7:0] o_tx_byte,
    input wire logic o_irq
);
    import lin_status_pkg::*;
    logic [15:0] mask_q;
    wire st_rd = i_req.rd && i_req.addr == `ADDR_STATUS;
    wire dat_wr = i_req.wr && i_req.addr == `ADDR_DATA;
    wire calm = !i_evt.frame_err && !i_evt.collision;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) mask_q <= 16'h0000;
        else if (i_req.wr && i_req.addr == `ADDR_IRQ_MASK) mask_q <= i_req.wdata;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_reserved_zero: assert property (st_rd |=> o_rdata[15:11] == 5'h00)
        else $error("reserved status bits set");
    a_pend_on_write: assert property (dat_wr && !i_evt.tx_loaded |=> o_tx_pending)
        else $error("tx pending not raised");
    a_pend_on_load: assert property (i_evt.tx_loaded && !dat_wr |=> !o_tx_pending)
        else $error("tx pending not dropped");
    a_tx_byte_kept: assert property (dat_wr && !i_evt.rx_byte |=> o_tx_byte == $past(i_req.wdata[7:0]))
        else $error("tx byte wrong");
    a_rx_ready_seen: assert property ((i_evt.rx_byte && !i_req.rd) ##1 st_rd |=> o_rdata[0])
        else $error("rx ready missing");
    // irq may be registered, so the mask must have been off for two cycles
    a_irq_masked_off: assert property (mask_q[5:1] == 5'h00 && $past(mask_q[5:1]) == 5'h00 |-> !o_irq)
        else $error("irq while masked");
    a_read_clears: assert property ((st_rd && calm) ##1 st_rd |=> (o_rdata & 16'h0050) == 16'h0000)
        else $error("flag survived read");
    a_event_kept: assert property ((st_rd && i_evt.frame_err) ##1 st_rd |=> o_rdata[6])
        else $error("same cycle event lost");
endmodule
`default_nettype wire

// ### dv/lin_bus_node.sv
// Purpose: other nodes on the shared bus line
// Assumes: line pulled high when nobody drives it
// Notes: low phase first, then falling edges
`timescale 1ns/1ps
`default_nettype none
module lin_bus_node (
    input wire logic i_clock,
    input wire logic i_go,
    input wire logic [15:0] i_low,
    input wire logic [7:0] i_edges,
    output logic o_rxd
);
    logic [15:0] low_q = 16'h0000;
    logic [7:0] edge_q = 8'h00;
    initial o_rxd = 1'b1;
    always @(posedge i_clock) begin
        if (i_go) begin
            low_q <= i_low;
            edge_q <= i_edges;
        end else if (low_q != 16'h0000) begin
            o_rxd <= 1'b0;
            low_q <= low_q - 16'h0001;
        end else if (edge_q != 8'h00) begin
            o_rxd <= ~o_rxd;
            if (!o_rxd) edge_q <= edge_q - 8'h01;
        end else o_rxd <= 1'b1;
    end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench of the bus status block
// Assumes: strobe register port, read data one cycle later
// Notes: short bit time keeps break waits small
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t %h not %h", $time, g, e); end end
module testbench;
    import lin_status_pkg::*;
    localparam int BITS = 4;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_low_power = 1'b0, i_frame_start = 1'b0, go = 1'b0, rd_d = 1'b0, rxd;
    reg_req_s i_req = '0;
    bus_events_s i_evt = '0;
    logic [15:0] o_rdata, low = 16'h0000, eq[$], mq[$];
    logic [7:0] o_tx_byte, edges = 8'h00, b, c;
    logic [31:0] seed = 32'h0001_31f8;
    logic o_tx_pending, o_enable, o_irq;
    int n_fail = 0, checks = 0;
    always #4 i_clock = ~i_clock;
    lin_status_flags #(.BIT_CLOCKS(BITS)) lin_status_flags_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_req(i_req), .o_rdata(o_rdata), .i_evt(i_evt), .i_rxd(rxd), .i_frame_start(i_frame_start),
        .i_low_power(i_low_power), .o_tx_pending(o_tx_pending), .o_tx_byte(o_tx_byte), .o_enable(o_enable),
        .o_irq(o_irq));
    lin_bus_node lin_bus_node_inst (.i_clock(i_clock), .i_go(go), .i_low(low), .i_edges(edges), .o_rxd(rxd));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic bad(input logic [7:0] v);
        return v[6] != (v[0] ^ v[1] ^ v[2] ^ v[4]) || v[7] != ~(v[1] ^ v[3] ^ v[4] ^ v[5]);
    endfunction
    task automatic cyc(input reg_req_s r, input bus_events_s e);
        i_req <= r;
        i_evt <= e;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] x, input logic [15:0] m, input bus_events_s e = '0);
        eq.push_back(x);
        mq.push_back(m);
        cyc('{a, 16'h0000, 1'b0, 1'b1}, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        cyc('{a, d, 1'b1, 1'b0}, '0);
    endtask
    task automatic ev(input bus_events_s e);
        cyc('0, e);
    endtask
    task automatic bus(input logic [15:0] l, input logic [7:0] n);
        low <= l;
        edges <= n;
        go <= 1'b1;
        ev('0);
        go <= 1'b0;
        repeat (l + 2 * n + 8) ev('0);
    endtask
    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // read answers stand only in the cycle after the strobe
    always @(posedge i_clock) begin
        if (rd_d) begin
            `CHK(o_rdata & mq[0], eq[0])
            void'(eq.pop_front());
            void'(mq.pop_front());
        end
        rd_d <= i_req.rd;
    end
    // roughly eighty times the expected run
    initial begin
        #200000;
        n_fail++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd(4'h0, 16'h0002, 16'hffff);
        wr(4'h4, 16'hffff);
        rd(4'h4, 16'h003e, 16'hffff);
        rd(4'h7, 16'h0000, 16'hffff);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            b = rnd();
            if (i == 0) b = {~(b[1] ^ b[3] ^ b[4] ^ b[5]), b[0] ^ b[1] ^ b[2] ^ b[4], b[5:0]};
            c = i[0] ? b : rnd();
            wr(4'h2, {8'h00, c});
            ev({8'h02, b});
            rd(4'h0, {7'h00, bad(b), b != c, 6'h00, 1'b1}, 16'h0181);
            rd(4'h1, {8'h00, b}, 16'hffff);
            rd(4'h0, 16'h0000, 16'h0001);
        end
        $display("receive test done");
        wr(4'h4, 16'h0004);
        wr(4'h1, {8'h00, rnd()});
        rd(4'h0, 16'h0000, 16'h0002);
        wr(4'h1, 16'h00a5);
        ev(16'h0800);
        rd(4'h0, 16'h0002, 16'h0006);
        `CHK(o_tx_byte, 8'ha5)
        ev(16'h0400);
        rd(4'h0, 16'h0004, 16'h0004);
        rd(4'h0, 16'h0004, 16'h0004);
        ev('0);
        `CHK(o_irq, 1'b1)
        ev(16'h0100);
        ev('0);
        ev('0);
        `CHK(o_irq, 1'b0)
        rd(4'h0, 16'h0000, 16'h0004);
        $display("transmit test done");
        ev(16'h0400);
        ev(16'h1000);
        rd(4'h0, 16'h0000, 16'h0010);
        wr(4'h3, 16'h0040);
        ev(16'h1000);
        rd(4'h0, 16'h0010, 16'h0010);
        rd(4'h0, 16'h0000, 16'h0010);
        rd(4'h0, 16'h0000, 16'h0040, 16'h2000);
        rd(4'h0, 16'h0040, 16'h0040);
        rd(4'h0, 16'h0000, 16'h0040);
        ev(16'h8000);
        rd(4'h0, 16'h0400, 16'h0400);
        rd(4'h0, 16'h0000, 16'h0400);
        i_low_power <= 1'b1;
        repeat (4) ev('0);
        ev(16'h8000);
        rd(4'h0, 16'h0000, 16'h0400);
        i_low_power <= 1'b0;
        wr(4'h3, 16'h0800);
        ev(16'h4000);
        rd(4'h0, 16'h0200, 16'h0200);
        `CHK(o_enable, 1'b1)
        ev(16'h4000);
        rd(4'h0, 16'h0000, 16'h0200);
        $display("flag test done");
        for (int k = 0; k < 2; k++) begin
            bus(16'(11 * BITS - 6 + 10 * k), 8'h00);
            rd(4'h0, {12'h000, k[0], 3'h0}, 16'h0008);
        end
        i_frame_start <= 1'b1;
        ev('0);
        i_frame_start <= 1'b0;
        bus(16'h0000, 8'h38);
        rd(4'h0, 16'h0000, 16'h0020);
        bus(16'h0000, 8'h01);
        rd(4'h0, 16'h0020, 16'h0020);
        ev('0);
        $display("bus test done");
        wrap_up;
    end
endmodule
bind lin_status_flags lin_status_properties lin_status_properties_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_req(i_req), .i_evt(i_evt), .o_rdata(o_rdata), .o_tx_pending(o_tx_pending), .o_tx_byte(o_tx_byte),
    .o_irq(o_irq));
`default_nettype wire
